// *** rtl/fts_monitor.sv ***
// one fan speed monitoring channel with its three registers
`timescale 1ns/100ps
`default_nettype none
module fts_monitor #(
  parameter int REF_CYCLES = fts_pkg::REF_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tach_input_pin,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic irq_clear,
  output logic irq_n,
  output logic [7:0] irq_source_id
);
  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    logic monitor_enable;
    logic speed_irq_enable;
    logic [1:0] divisor_sel;
    logic [7:0] threshold_bits;
    logic [7:0] count_bits;
    logic [7:0] counter;
    logic [fts_pkg::REF_W-1:0] ref_div;
    logic [2:0] prescale;
    fts_pkg::fts_state_e state;
    logic pending;
  } fts_main_s;

  fts_main_s q, d;
  logic tach_rise;
  logic ref_tick;
  logic count_tick;
  logic [2:0] div_m1;

  fts_tach_filter u_filter (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .tach_input_pin(tach_input_pin),
    .tach_rise(tach_rise)
  );

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    d = q;
    ref_tick = 1'b0;
    count_tick = 1'b0;
    div_m1 = 3'((4'h1 << q.divisor_sel) - 4'h1);
    if (reg_wr && reg_addr == fts_pkg::ADDR_CTRL) begin
      d.monitor_enable = reg_wdata[fts_pkg::CTRL_ENABLE_BIT];
      d.speed_irq_enable = reg_wdata[fts_pkg::CTRL_IRQ_EN_BIT];
      d.divisor_sel = reg_wdata[fts_pkg::CTRL_DIV_HI_BIT:fts_pkg::CTRL_DIV_LO_BIT];
    end
    if (reg_wr && reg_addr == fts_pkg::ADDR_THRESHOLD) begin
      d.threshold_bits = reg_wdata;
    end
    if (!q.monitor_enable) begin
      // disabled channel shows no count and holds no interrupt
      d.count_bits = fts_pkg::COUNT_NONE;
      d.counter = '0;
      d.ref_div = '0;
      d.prescale = '0;
      d.state = fts_pkg::FTS_WAIT_EDGE;
      d.pending = 1'b0;
    end else begin
      if (q.ref_div == fts_pkg::REF_W'(REF_CYCLES - 1)) begin
        d.ref_div = '0;
        ref_tick = 1'b1;
      end else begin
        d.ref_div = q.ref_div + 1'b1;
      end
      if (ref_tick) begin
        if (q.prescale == div_m1) begin
          d.prescale = '0;
          count_tick = 1'b1;
        end else begin
          d.prescale = q.prescale + 1'b1;
        end
      end
      if (count_tick && q.counter != fts_pkg::COUNT_MAX) begin
        d.counter = q.counter + 1'b1;
      end
      if (q.counter == fts_pkg::COUNT_MAX && !q.pending) begin
        d.count_bits = fts_pkg::COUNT_MAX;
      end
      case (q.state)
        fts_pkg::FTS_WAIT_EDGE: begin
          if (tach_rise) begin
            d.state = fts_pkg::FTS_HALF_A;
            d.counter = '0;
          end
        end
        fts_pkg::FTS_HALF_A: begin
          if (tach_rise) begin
            d.state = fts_pkg::FTS_HALF_B;
          end
        end
        fts_pkg::FTS_HALF_B: begin
          // second pulse closes the revolution
          if (tach_rise) begin
            d.state = fts_pkg::FTS_HALF_A;
            d.counter = '0;
            if (!q.pending) begin
              d.count_bits = q.counter;
            end
          end
        end
        default: begin
          d.state = fts_pkg::FTS_WAIT_EDGE;
        end
      endcase
      if (irq_clear && q.pending) begin
        // restart so the next value is a whole revolution
        d.count_bits = fts_pkg::COUNT_NONE;
        d.counter = '0;
        d.state = fts_pkg::FTS_WAIT_EDGE;
      end
      // a new overflow in the clearing cycle keeps the flag set
      d.pending = q.speed_irq_enable &&
                  ((q.counter > q.threshold_bits) || (q.pending && !irq_clear));
    end
    // a new divisor starts from a clean prescale phase, never above its limit
    if (reg_wr && reg_addr == fts_pkg::ADDR_CTRL) begin
      d.prescale = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.state <= fts_pkg::FTS_WAIT_EDGE;
      q.threshold_bits <= fts_pkg::RESET_THRESHOLD;
      q.count_bits <= fts_pkg::RESET_COUNT;
    end else begin
      q <= d;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign irq_n = ~q.pending;
  assign irq_source_id = q.pending ? fts_pkg::ADDR_CTRL : fts_pkg::IRQ_ID_NONE;

  always_comb begin
    case (reg_addr)
      fts_pkg::ADDR_CTRL: begin
        reg_rdata = {q.monitor_enable, q.speed_irq_enable, 4'h0, q.divisor_sel};
      end
      fts_pkg::ADDR_THRESHOLD: begin
        reg_rdata = q.threshold_bits;
      end
      fts_pkg::ADDR_COUNT: begin
        reg_rdata = q.count_bits;
      end
      default: begin
        reg_rdata = 8'h00;
      end
    endcase
  end

  // ********************************************************************
  // assertions
  // ********************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_count_off_zero: assert property (
    (!q.monitor_enable && $past(!q.monitor_enable)) |-> q.count_bits == 8'h00)
    else $error("count not zero while disabled");
  a_ref_period: assert property (
    q.ref_div < fts_pkg::REF_W'(REF_CYCLES))
    else $error("reference divider out of range");
  a_prescale_range: assert property (
    q.monitor_enable |-> q.prescale <= div_m1 || $changed(q.divisor_sel))
    else $error("prescaler beyond divisor");
  a_counter_sat: assert property (
    (q.monitor_enable && q.counter == 8'hFF && !tach_rise && !irq_clear)
      |=> q.counter == 8'hFF || !q.monitor_enable)
    else $error("counter wrapped past maximum");
  a_polled_load: assert property (
    (q.monitor_enable && !q.pending && q.state == fts_pkg::FTS_HALF_B && tach_rise
      && !irq_clear) |=> q.count_bits == $past(q.counter))
    else $error("revolution count not loaded");
  a_irq_raise: assert property (
    (q.monitor_enable && q.speed_irq_enable && q.counter > q.threshold_bits)
      |=> !irq_n)
    else $error("overflow did not raise interrupt");
  a_freeze_count: assert property (
    (q.pending && !irq_clear && q.monitor_enable) |=> $stable(q.count_bits))
    else $error("count changed while interrupt pending");
  a_clear_zero: assert property (
    (q.monitor_enable && q.pending && irq_clear) |=> q.count_bits == 8'h00)
    else $error("clearing interrupt left count");
  a_source_id: assert property (
    !irq_n |-> irq_source_id == 8'h44)
    else $error("source id wrong while interrupt asserted");
  a_polled_quiet: assert property (
    $past(!q.speed_irq_enable) |-> irq_n)
    else $error("interrupt in polled mode");

  c_revolution: cover property (q.state == fts_pkg::FTS_HALF_B && tach_rise);
  c_irq_raised: cover property ($fell(irq_n));
  c_saturated: cover property (q.count_bits == 8'hFF);
  c_irq_cleared: cover property (q.pending && irq_clear);
endmodule : fts_monitor
`default_nettype wire

// *** rtl/fts_pkg.sv ***
// constants, field layout and state type of the fan tachometer speed monitor
package fts_pkg;
  // ********************************************************************
  // register map
  // ********************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h44;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h45;
  localparam logic [7:0] ADDR_COUNT = 8'h46;
  localparam int CTRL_ENABLE_BIT = 7;
  localparam int CTRL_IRQ_EN_BIT = 6;
  localparam int CTRL_DIV_HI_BIT = 1;
  localparam int CTRL_DIV_LO_BIT = 0;
  localparam logic [7:0] RESET_CTRL = 8'h00;
  localparam logic [7:0] RESET_THRESHOLD = 8'h00;
  localparam logic [7:0] RESET_COUNT = 8'h00;
  localparam logic [7:0] COUNT_NONE = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] IRQ_ID_NONE = 8'h00;

  // ********************************************************************
  // timing
  // ********************************************************************
  localparam int CLK_HZ = 200000000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int REF_HZ = 20000;
  localparam int REF_CYCLES = CLK_HZ / REF_HZ;
  // tach edges are slow; a level must hold this long to be believed
  localparam int FILTER_NS = 10000;
  localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILTER_W = 12;
  localparam int REF_W = 14;

  typedef enum logic [1:0] {
    FTS_WAIT_EDGE,
    FTS_HALF_A,
    FTS_HALF_B
  } fts_state_e;
endpackage : fts_pkg

// *** rtl/fts_tach_filter.sv ***
// synchroniser, slow-edge filter and rising-edge detector for the tach pin
`timescale 1ns/100ps
`default_nettype none
module fts_tach_filter (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic tach_input_pin,
  output logic tach_rise
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic level;
    logic [fts_pkg::FILTER_W-1:0] hold;
    logic rise;
  } fts_filt_s;

  fts_filt_s q, d;

  always_comb begin
    d = q;
    d.sync1 = tach_input_pin;
    d.sync2 = q.sync1;
    d.rise = 1'b0;
    if (q.sync2 == q.level) begin
      d.hold = '0;
    end else if (q.hold == fts_pkg::FILTER_W'(fts_pkg::FILTER_CYCLES - 1)) begin
      d.hold = '0;
      d.level = q.sync2;
      d.rise = q.sync2;
    end else begin
      d.hold = q.hold + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      // pin idles high on its pull-up; a low reset level would fake a first edge
      q <= '{sync1: 1'b1, sync2: 1'b1, level: 1'b1, hold: '0, rise: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign tach_rise = q.rise;
endmodule : fts_tach_filter
`default_nettype wire

// *** test/fts_fan_model.sv ***
// behavioural fan tachometer driving the speed monitor's tach pin
`timescale 1ns/100ps
`default_nettype none
module fts_fan_model (
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [15:0] half_hi,
  input wire logic [15:0] half_lo,
  output logic tach_input_pin
);
  logic [15:0] cnt_q = 16'h0000;
  logic tach_q = 1'b1;
  assign tach_input_pin = tach_q;
  // one high plus one low phase is one pulse; two pulses per revolution
  always_ff @(posedge sys_clk) begin
    if (!run) begin
      // stopped fan: output parks at its pull-up level, with at most one rise to reach it
      tach_q <= 1'b1;
      cnt_q <= 16'h0000;
    end else if (cnt_q + 16'h0001 >= (tach_q ? half_hi : half_lo)) begin
      tach_q <= ~tach_q;
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule : fts_fan_model
`default_nettype wire

// *** test/fts_monitor_tb.sv ***
// self-checking testbench of the fan speed monitor channel
`timescale 1ns/100ps
`default_nettype none
module fts_monitor_tb;
  localparam int REF = 40;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic tach, reg_wr = 1'b0, irq_clear = 1'b0, irq_n, run = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, irq_source_id, v, v1;
  logic [15:0] hi = 16'h0834, lo = 16'h0834;
  int fail_count = 0, tests_run = 0, p, n;

  fts_fan_model fts_fan_model_i (.sys_clk(sys_clk), .run(run), .half_hi(hi), .half_lo(lo),
    .tach_input_pin(tach));
  fts_monitor #(.REF_CYCLES(REF)) fts_monitor_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .tach_input_pin(tach), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .irq_clear(irq_clear), .irq_n(irq_n),
    .irq_source_id(irq_source_id));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ********************************************************************
  // bus tasks and comparison
  // ********************************************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd

  // tolerance covers the unknown phase of the reference tick
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input int tol);
    tests_run++;
    if ((^got === 1'bx) || (int'(got) > int'(exp) + tol) || (int'(got) + tol < int'(exp))) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] exp_count(input int per, input int code);
    int c;
    c = (2 * per) / (REF * (1 << code));
    return (c > 255) ? 8'hFF : 8'(c);
  endfunction : exp_count

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  initial begin
    // longest clean run: four divisor passes of 2 revolutions plus irq and saturation waits
    repeat (105000) @(posedge sys_clk);
    fail_count++;
    end_of_test();
  end

  // ********************************************************************
  // scenarios
  // ********************************************************************
  initial begin
    void'($urandom(12));
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    hi <= 16'(2050 + $urandom % 150);
    lo <= 16'(2050 + $urandom % 150);
    chk({7'h00, irq_n}, 8'h01, 0);
    chk(irq_source_id, fts_pkg::IRQ_ID_NONE, 0);
    rd(fts_pkg::ADDR_THRESHOLD, v);
    chk(v, 8'h00, 0);
    rd(fts_pkg::ADDR_COUNT, v);
    chk(v, 8'h00, 0);
    wr(fts_pkg::ADDR_CTRL, 8'h3C);
    rd(fts_pkg::ADDR_CTRL, v);
    chk(v, 8'h00, 0);
    wr(fts_pkg::ADDR_COUNT, 8'h5A);
    rd(fts_pkg::ADDR_COUNT, v);
    chk(v, 8'h00, 0);
    rd(8'h50, v);
    chk(v, 8'h00, 0);
    p = int'(hi) + int'(lo);
    run <= 1'b1;
    for (int code = 0; code < 4; code++) begin
      wr(fts_pkg::ADDR_CTRL, 8'h80 | 8'(code));
      repeat (4 * p + 500) @(posedge sys_clk);
      rd(fts_pkg::ADDR_COUNT, v);
      chk(v, exp_count(p, code), 2);
    end
    wr(fts_pkg::ADDR_CTRL, 8'h00);
    rd(fts_pkg::ADDR_COUNT, v);
    chk(v, 8'h00, 0);
    wr(fts_pkg::ADDR_THRESHOLD, 8'h0A);
    wr(fts_pkg::ADDR_CTRL, 8'hC3);
    n = 0;
    while (irq_n !== 1'b0 && n < 30000) begin
      @(negedge sys_clk);
      n++;
    end
    chk({7'h00, irq_n}, 8'h00, 0);
    chk(irq_source_id, fts_pkg::ADDR_CTRL, 0);
    rd(fts_pkg::ADDR_COUNT, v1);
    repeat (2 * p + 200) @(posedge sys_clk);
    rd(fts_pkg::ADDR_COUNT, v);
    chk(v, v1, 0);
    @(posedge sys_clk);
    irq_clear <= 1'b1;
    @(posedge sys_clk);
    irq_clear <= 1'b0;
    rd(fts_pkg::ADDR_COUNT, v);
    chk(v, 8'h00, 0);
    run <= 1'b0;
    wr(fts_pkg::ADDR_CTRL, 8'h00);
    wr(fts_pkg::ADDR_CTRL, 8'h80);
    rd(fts_pkg::ADDR_COUNT, v);
    chk(v, 8'h00, 0);
    // the stopped pin may still show one late filtered rise that restarts the counter
    repeat (255 * REF + 2500) @(posedge sys_clk);
    rd(fts_pkg::ADDR_COUNT, v);
    chk(v, 8'hFF, 0);
    end_of_test();
  end
endmodule : fts_monitor_tb
`default_nettype wire
